// [core/port_c_pkg.sv]
// package with register map, reset values and carrier types for the upper port pin mux
package port_c_pkg;

    // ----------------------------------------
    // register offsets and reset values
    // ----------------------------------------
    localparam logic [1:0] off_pin_value = 2'h0;
    localparam logic [1:0] off_output_latch = 2'h1;
    localparam logic [1:0] off_direction = 2'h2;
    localparam logic [7:0] direction_reset = 8'hff;
    localparam logic [7:0] latch_reset = 8'h00;
    localparam logic [7:0] unmapped_read = 8'h00;

    // ----------------------------------------
    // pin positions
    // ----------------------------------------
    localparam int pin_3 = 3;
    localparam int pin_4 = 4;
    localparam int pin_5 = 5;
    localparam int pin_6 = 6;
    localparam int pin_7 = 7;
    localparam int pin_1 = 1;

    // register bus request
    typedef struct packed {
        logic [1:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } reg_req_t;

    // peripheral requests toward the pins
    typedef struct packed {
        logic i2c_en;
        logic i2c_smbus_levels;
        logic i2c_clock_drive;
        logic i2c_clock_out;
        logic i2c_data_drive;
        logic i2c_data_out;
        logic spi_en;
        logic spi_clock_master;
        logic spi_clock_out;
        logic spi_data_out;
        logic usart_en;
        logic usart_sync;
        logic usart_master;
        logic usart_sync_tx;
        logic usart_tx_out;
        logic usart_sync_clock_out;
        logic usart_sync_data_out;
    } periph_req_t;

    // pin outputs bundle
    typedef struct packed {
        logic [7:0] out;
        logic [7:0] oe;
        logic [7:0] smbus_sel;
    } pin_drive_t;

endpackage

// [core/pin_cell.sv]
// one pin cell: direction, override mux and input sampling
module pin_cell (
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic latch_bit,
    input wire logic dir_bit,
    input wire logic ovr_en,
    input wire logic ovr_val,
    input wire logic pad_in,
    output logic pad_out,
    output logic pad_oe,
    output logic sampled
);

    logic out_next;
    logic oe_next;
    logic samp_next;

    // peripheral owns the pin when asked; otherwise direction picks latch or input
    always_comb begin
        out_next = ovr_en ? ovr_val : latch_bit;
        oe_next = ovr_en | ~dir_bit;
        samp_next = pad_in; // schmitt path modelled as plain sample
    end

    // registered so pin outputs come from flops
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            pad_out <= 1'b0;
            pad_oe <= 1'b0;
            sampled <= 1'b0;
        end else begin
            pad_out <= out_next;
            pad_oe <= oe_next;
            sampled <= samp_next;
        end
    end

endmodule

// [core/port_c_upper_pin_mux.sv]
// upper port pin mux with pin value, output latch and direction registers
// Function
// - pin value reads eight sampled pin levels
// - output latch reads back latched value
// - i2c clock output overrides latch on pin 3
// - i2c or smbus input levels by serial config
// - i2c data output overrides pin 4 while data drive is set
// - spi mode: pin 4 is serial data input
// - spi mode: pin 5 carries serial data output
// - pin 6 carries usart asynchronous transmit output
// - sync master: pin 6 carries clock output
// - sync slave: pin 6 feeds clock input
// - async: pin 7 feeds receive data input
// - sync transmit: pin 7 carries data output
// - direction ignored where peripheral owns pin
// - capture pin on pin 1 when map set
// - direction read returns stored contents always
// - reset makes every pin an input
module port_c_upper_pin_mux (
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic [1:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    input wire logic [7:0] pad_in,
    output logic [7:0] pad_out,
    output logic [7:0] pad_oe,
    output logic i2c_smbus_sel,
    input wire port_c_pkg::periph_req_t periph,
    input wire logic [2:0] low_pin_ovr_en,
    input wire logic [2:0] low_pin_ovr_val,
    input wire logic capture_pin_map_select,
    input wire logic second_capture_compare_out,
    input wire logic second_capture_compare_drive,
    output logic second_capture_compare_in,
    output logic port_b_pin_3_ovr_en,
    output logic port_b_pin_3_ovr_val,
    output logic sync_serial_clock_in,
    output logic sync_serial_data_in,
    output logic usart_rx_in,
    output logic usart_sync_clock,
    output logic usart_sync_data
);

    // ----------------------------------------
    // register file
    // ----------------------------------------
    port_c_pkg::reg_req_t req;
    logic [7:0] latch_reg;
    logic [7:0] latch_next;
    logic [7:0] dir_reg;
    logic [7:0] dir_next;
    logic [7:0] rdata_next;
    logic [7:0] sampled;

    assign req = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};

    // writes to pin value or latch both land in the latch
    always_comb begin
        latch_next = latch_reg;
        dir_next = dir_reg;
        if (req.wr) begin
            if (req.addr == port_c_pkg::off_pin_value || req.addr == port_c_pkg::off_output_latch) begin
                latch_next = req.wdata;
            end
            if (req.addr == port_c_pkg::off_direction) begin
                dir_next = req.wdata;
            end
        end
    end

    // read data valid only the cycle after the strobe
    always_comb begin
        rdata_next = 8'h00;
        if (req.rd) begin
            unique case (req.addr)
                port_c_pkg::off_pin_value: rdata_next = sampled;
                port_c_pkg::off_output_latch: rdata_next = latch_reg;
                port_c_pkg::off_direction: rdata_next = dir_reg; // stored value, not overridden
                default: rdata_next = port_c_pkg::unmapped_read;
            endcase
        end
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            latch_reg <= port_c_pkg::latch_reset;
            dir_reg <= port_c_pkg::direction_reset;
            reg_rdata <= 8'h00;
        end else begin
            latch_reg <= latch_next;
            dir_reg <= dir_next;
            reg_rdata <= rdata_next;
        end
    end

    // ----------------------------------------
    // override selection
    // ----------------------------------------
    logic [7:0] ovr_en;
    logic [7:0] ovr_val;
    logic ccp_here;

    // priority per pin: i2c over spi, usart modes are exclusive by construction
    always_comb begin
        ovr_en = 8'h00;
        ovr_val = 8'h00;
        ccp_here = capture_pin_map_select & second_capture_compare_drive;
        ovr_en[2:0] = low_pin_ovr_en;
        ovr_val[2:0] = low_pin_ovr_val;
        if (ccp_here) begin
            ovr_en[port_c_pkg::pin_1] = 1'b1;
            ovr_val[port_c_pkg::pin_1] = second_capture_compare_out;
        end
        // pin 3: i2c clock first, then spi master clock
        if (periph.i2c_en && periph.i2c_clock_drive) begin
            ovr_en[port_c_pkg::pin_3] = 1'b1;
            ovr_val[port_c_pkg::pin_3] = periph.i2c_clock_out;
        end else if (periph.spi_en && periph.spi_clock_master) begin
            ovr_en[port_c_pkg::pin_3] = 1'b1;
            ovr_val[port_c_pkg::pin_3] = periph.spi_clock_out;
        end
        // pin 4: i2c data drives regardless of direction
        if (periph.i2c_en && periph.i2c_data_drive) begin
            ovr_en[port_c_pkg::pin_4] = 1'b1;
            ovr_val[port_c_pkg::pin_4] = periph.i2c_data_out;
        end
        // pin 5: spi data out
        if (periph.spi_en) begin
            ovr_en[port_c_pkg::pin_5] = 1'b1;
            ovr_val[port_c_pkg::pin_5] = periph.spi_data_out;
        end
        // pin 6: async tx or sync master clock
        if (periph.usart_en && !periph.usart_sync) begin
            ovr_en[port_c_pkg::pin_6] = 1'b1;
            ovr_val[port_c_pkg::pin_6] = periph.usart_tx_out;
        end else if (periph.usart_en && periph.usart_master) begin
            ovr_en[port_c_pkg::pin_6] = 1'b1;
            ovr_val[port_c_pkg::pin_6] = periph.usart_sync_clock_out;
        end
        // pin 7: sync transmit data only; receive leaves direction to software
        if (periph.usart_en && periph.usart_sync && periph.usart_sync_tx) begin
            ovr_en[port_c_pkg::pin_7] = 1'b1;
            ovr_val[port_c_pkg::pin_7] = periph.usart_sync_data_out;
        end
    end

    // ----------------------------------------
    // pin cells
    // ----------------------------------------
    for (genvar i = 0; i < 8; i++) begin : g_pin
        pin_cell u_cell (
            .mclk(mclk),
            .rst_b(rst_b),
            .latch_bit(latch_reg[i]),
            .dir_bit(dir_reg[i]),
            .ovr_en(ovr_en[i]),
            .ovr_val(ovr_val[i]),
            .pad_in(pad_in[i]),
            .pad_out(pad_out[i]),
            .pad_oe(pad_oe[i]),
            .sampled(sampled[i])
        );
    end

    // ----------------------------------------
    // peripheral input routing
    // ----------------------------------------
    logic smbus_next;
    logic ccp_in_next;
    logic pb3_en_next;
    logic pb3_val_next;
    logic [4:0] periph_in_next;

    // inputs taken from sampled pins; slight lag traded for flop outputs
    always_comb begin
        smbus_next = periph.i2c_en & periph.i2c_smbus_levels;
        ccp_in_next = capture_pin_map_select ? sampled[port_c_pkg::pin_1] : 1'b0;
        pb3_en_next = ~capture_pin_map_select & second_capture_compare_drive;
        pb3_val_next = second_capture_compare_out;
        periph_in_next[0] = sampled[port_c_pkg::pin_3];
        periph_in_next[1] = periph.spi_en ? sampled[port_c_pkg::pin_4] : 1'b0;
        periph_in_next[2] = (periph.usart_en && !periph.usart_sync) ? sampled[port_c_pkg::pin_7] : 1'b1;
        periph_in_next[3] = (periph.usart_sync && !periph.usart_master) ? sampled[port_c_pkg::pin_6] : 1'b0;
        // software keeps pin 7 input while receiving
        periph_in_next[4] = periph.usart_sync ? sampled[port_c_pkg::pin_7] : 1'b0;
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            i2c_smbus_sel <= 1'b0;
            second_capture_compare_in <= 1'b0;
            port_b_pin_3_ovr_en <= 1'b0;
            port_b_pin_3_ovr_val <= 1'b0;
            sync_serial_clock_in <= 1'b0;
            sync_serial_data_in <= 1'b0;
            usart_rx_in <= 1'b1;
            usart_sync_clock <= 1'b0;
            usart_sync_data <= 1'b0;
        end else begin
            i2c_smbus_sel <= smbus_next;
            second_capture_compare_in <= ccp_in_next;
            port_b_pin_3_ovr_en <= pb3_en_next;
            port_b_pin_3_ovr_val <= pb3_val_next;
            sync_serial_clock_in <= periph_in_next[0];
            sync_serial_data_in <= periph_in_next[1];
            usart_rx_in <= periph_in_next[2];
            usart_sync_clock <= periph_in_next[3];
            usart_sync_data <= periph_in_next[4];
        end
    end

endmodule

// [verification/pin_mux_checker.sv]
// assertion checker for the upper port pin mux
module pin_mux_checker (
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic [1:0] reg_addr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic [7:0] pad_in,
    input wire logic [7:0] pad_out,
    input wire logic [7:0] pad_oe,
    input wire logic i2c_smbus_sel,
    input wire port_c_pkg::periph_req_t periph,
    input wire logic usart_rx_in
);
    // ----------------------------------------
    // bus and pin properties
    // ----------------------------------------
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_b);

    rdata_idle_a: assert property (!reg_rd |=> reg_rdata == 8'h00)
        else $error("read data not zero outside a read");
    unmapped_read_a: assert property (reg_rd && reg_addr == 2'h3 |=> reg_rdata == port_c_pkg::unmapped_read)
        else $error("unmapped read returned data");
    reset_inputs_a: assert property ($rose(rst_b) |-> pad_oe == 8'h00)
        else $error("pins not inputs after reset");
    i2c_clock_out_a: assert property (periph.i2c_en && periph.i2c_clock_drive
        |=> pad_oe[3] && pad_out[3] == $past(periph.i2c_clock_out)) else $error("pin 3 clock drive wrong");
    i2c_data_out_a: assert property (periph.i2c_en && periph.i2c_data_drive
        |=> pad_oe[4] && pad_out[4] == $past(periph.i2c_data_out)) else $error("pin 4 data drive wrong");
    spi_data_out_a: assert property (periph.spi_en
        |=> pad_oe[5] && pad_out[5] == $past(periph.spi_data_out)) else $error("pin 5 data drive wrong");
    async_tx_out_a: assert property (periph.usart_en && !periph.usart_sync
        |=> pad_oe[6] && pad_out[6] == $past(periph.usart_tx_out)) else $error("pin 6 transmit drive wrong");
    sync_clock_out_a: assert property (periph.usart_en && periph.usart_sync && periph.usart_master
        |=> pad_oe[6] && pad_out[6] == $past(periph.usart_sync_clock_out)) else $error("pin 6 clock drive wrong");
    sync_data_out_a: assert property (periph.usart_en && periph.usart_sync && periph.usart_sync_tx
        |=> pad_oe[7] && pad_out[7] == $past(periph.usart_sync_data_out)) else $error("pin 7 data drive wrong");
    // mode held three edges so the two-stage input path is settled
    rx_path_a: assert property ((periph.usart_en && !periph.usart_sync) [*3]
        |-> usart_rx_in == $past(pad_in[7], 2)) else $error("receive input does not follow pin 7");
    smbus_select_a: assert property (periph.i2c_en && periph.i2c_smbus_levels |=> i2c_smbus_sel)
        else $error("input level select not raised");
endmodule

bind port_c_upper_pin_mux pin_mux_checker chk_u (.mclk(mclk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .pad_in(pad_in), .pad_out(pad_out), .pad_oe(pad_oe), .i2c_smbus_sel(i2c_smbus_sel),
    .periph(periph), .usart_rx_in(usart_rx_in));

// [verification/board_pins.sv]
// board side of the port pins
module board_pins (
    input wire logic [7:0] pad_out,
    input wire logic [7:0] pad_oe,
    input wire logic [7:0] ext_level,
    output logic [7:0] pad_in
);
    // ----------------------------------------
    // pin levels
    // ----------------------------------------
    // a released pin shows the board level, never a stale drive
    assign pad_in = (pad_oe & pad_out) | (~pad_oe & ext_level);
endmodule

// [verification/tb_top.sv]
// self-checking bench for the upper port pin mux
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed {logic [1:0] wa; logic [7:0] wd; logic [1:0] ra; logic [7:0] exp;} reg_row_t;
    typedef struct packed {logic [16:0] p; logic [7:0] ext; logic [7:0] oe; logic [7:0] out; logic [4:0] ins;} pin_row_t;
    logic mclk = 1'b0;
    logic rst_b = 1'b0;
    logic [1:0] reg_addr = 2'h0;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [7:0] ext_level = 8'h3c;
    logic [7:0] reg_rdata;
    logic [7:0] pad_in;
    logic [7:0] pad_out;
    logic [7:0] pad_oe;
    logic i2c_smbus_sel;
    logic capture_map = 1'b1;
    logic capture_out = 1'b0;
    logic capture_drive = 1'b0;
    logic capture_in;
    logic pb_drive_en;
    logic pb_drive_val;
    wire logic [4:0] ins;
    port_c_pkg::periph_req_t periph = '0;
    int err_count = 0;
    int comparisons = 0;
    reg_row_t rrows [6] = '{'{2'h1, 8'h5a, 2'h1, 8'h5a}, '{2'h0, 8'ha5, 2'h1, 8'ha5}, '{2'h2, 8'h0f, 2'h2, 8'h0f},
        '{2'h3, 8'h33, 2'h3, 8'h00}, '{2'h2, 8'h00, 2'h0, 8'ha5}, '{2'h2, 8'hff, 2'h0, 8'h3c}};
    // ins is serial clock in, usart receive, usart sync clock, serial data in, usart sync data
    pin_row_t prows [9] = '{'{17'h1e000, 8'h00, 8'h08, 8'h08, 5'h18}, '{17'h11800, 8'h00, 8'h10, 8'h10, 5'h08},
        '{17'h00480, 8'h00, 8'h20, 8'h20, 5'h08}, '{17'h00044, 8'h00, 8'h40, 8'h40, 5'h00},
        '{17'h00072, 8'h00, 8'h40, 8'h40, 5'h08}, '{17'h00069, 8'h00, 8'h80, 8'h80, 5'h09},
        '{17'h00060, 8'hc0, 8'h00, 8'h00, 5'h0d}, '{17'h00400, 8'h10, 8'h20, 8'h00, 5'h0a},
        '{17'h00700, 8'h00, 8'h28, 8'h08, 5'h18}};

    // ----------------------------------------
    // clock, design and board
    // ----------------------------------------
    always #12.5 mclk = ~mclk;

    // low pins tied off, their logic lies outside these pins
    port_c_upper_pin_mux dut_u (.mclk(mclk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pad_in(pad_in), .pad_out(pad_out), .pad_oe(pad_oe),
        .i2c_smbus_sel(i2c_smbus_sel), .periph(periph), .low_pin_ovr_en(3'h0), .low_pin_ovr_val(3'h0),
        .capture_pin_map_select(capture_map), .second_capture_compare_out(capture_out),
        .second_capture_compare_drive(capture_drive), .second_capture_compare_in(capture_in),
        .port_b_pin_3_ovr_en(pb_drive_en), .port_b_pin_3_ovr_val(pb_drive_val), .sync_serial_clock_in(ins[4]),
        .sync_serial_data_in(ins[1]), .usart_rx_in(ins[3]), .usart_sync_clock(ins[2]), .usart_sync_data(ins[0]));
    board_pins brd_u (.pad_out(pad_out), .pad_oe(pad_oe), .ext_level(ext_level), .pad_in(pad_in));

    // ----------------------------------------
    // tasks
    // ----------------------------------------
    task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp) begin
            err_count++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic wr(input logic [1:0] a, input logic [7:0] d);
        @(posedge mclk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge mclk);
        reg_wr <= 1'b0;
    endtask
    // read data stand only in the cycle after the strobe
    task automatic rd(input logic [1:0] a, input logic [7:0] exp);
        @(posedge mclk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge mclk);
        reg_rd <= 1'b0;
        #1;
        chk("reg_rdata", reg_rdata, exp);
    endtask
    task automatic report_and_stop;
        if (err_count == 0 && comparisons > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // ----------------------------------------
    // sequence
    // ----------------------------------------
    initial begin
        repeat (12) @(posedge mclk);
        rst_b <= 1'b1;
        rd(2'h2, 8'hff);
        foreach (rrows[i]) begin
            wr(rrows[i].wa, rrows[i].wd);
            repeat (3) @(posedge mclk);
            rd(rrows[i].ra, rrows[i].exp);
        end
        // latch zero and all pins inputs, so any drive comes from a peripheral
        wr(2'h1, 8'h00);
        foreach (prows[i]) begin
            @(posedge mclk);
            periph <= prows[i].p;
            ext_level <= prows[i].ext;
            repeat (4) @(posedge mclk);
            #1;
            chk("pad_oe", pad_oe, prows[i].oe);
            chk("pad_out", pad_out, prows[i].out);
            chk("periph_in", {3'h0, ins}, {3'h0, prows[i].ins});
        end
        // direction read while pins 3 and 5 are still overridden
        rd(2'h2, 8'hff);
        // capture unit on pin 1 first, then moved to port b
        @(posedge mclk);
        periph <= '0;
        capture_drive <= 1'b1;
        capture_out <= 1'b1;
        repeat (4) @(posedge mclk);
        #1;
        chk("pin1_oe", {7'h0, pad_oe[1]}, 8'h01);
        chk("capture_in", {7'h0, capture_in}, 8'h01);
        chk("port_b_drive", {7'h0, pb_drive_en}, 8'h00);
        @(posedge mclk);
        capture_map <= 1'b0;
        repeat (4) @(posedge mclk);
        #1;
        chk("pin1_oe", {7'h0, pad_oe[1]}, 8'h00);
        chk("capture_in", {7'h0, capture_in}, 8'h00);
        chk("port_b_drive", {6'h0, pb_drive_en, pb_drive_val}, 8'h03);
        @(posedge mclk);
        capture_drive <= 1'b0;
        wr(2'h2, 8'h00);
        repeat (3) @(posedge mclk);
        rst_b <= 1'b0;
        @(posedge mclk);
        rst_b <= 1'b1;
        #1;
        chk("pad_oe", pad_oe, 8'h00);
        rd(2'h2, 8'hff);
        report_and_stop;
    end

    // hang guard, well past the roughly 125 cycles the sequence needs
    initial begin
        repeat (2000) @(posedge mclk);
        err_count++;
        report_and_stop;
    end
endmodule
